// [inc/sleep_ctl_pkg.sv]
`default_nettype none
package sleep_ctl_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_MODE      = 8'h00;
  localparam logic [7:0] ADDR_OPTIONS   = 8'h04;
  localparam logic [7:0] ADDR_SLEEP_PER = 8'h08;
  localparam logic [7:0] ADDR_WAKE_PER  = 8'h0C;
  localparam logic [7:0] ADDR_RATE      = 8'h10;
  localparam logic [7:0] ADDR_STATUS    = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h1C;

  // Mode codes
  localparam logic [3:0] MODE_AWAKE     = 4'h0;
  localparam logic [3:0] MODE_PIN       = 4'h1;
  localparam logic [3:0] MODE_CYCLIC    = 4'h4;
  localparam logic [3:0] MODE_CYC_PIN   = 4'h5;
  localparam logic [3:0] MODE_SUPPORT   = 4'h7;
  localparam logic [3:0] MODE_SYNC      = 4'h8;

  // Option bit positions
  localparam int OPT_PREF_COORD = 0;
  localparam int OPT_NON_COORD  = 1;
  localparam int OPT_STATUS_MSG = 2;
  localparam int OPT_NO_EARLY   = 3;
  localparam int OPT_EQUALITY   = 4;
  localparam int OPT_NO_DEPLOY  = 5;
  localparam int OPT_FULL_WAKE  = 8;

  localparam logic [8:0]  OPTIONS_MAX   = 9'h13E;
  localparam logic [8:0]  OPTIONS_RST   = 9'h002;
  localparam logic [3:0]  MODE_RST      = 4'h0;
  localparam logic [21:0] SLEEP_PER_MIN = 22'h000001;
  localparam logic [21:0] SLEEP_PER_MAX = 22'h15F900;
  localparam logic [21:0] SLEEP_PER_RST = 22'h00012C;
  localparam logic [21:0] WAKE_PER_MIN  = 22'h000001;
  localparam logic [21:0] WAKE_PER_MAX  = 22'h36EE80;
  localparam logic [21:0] WAKE_PER_RST  = 22'h000D08;
  localparam logic [7:0]  RATE_RST      = 8'h01;

  // Timebase
  localparam int CLK_HZ      = 20_000_000;
  localparam int TICK_1MS_US = 1000;
  localparam int TICK_1MS_CYC = CLK_HZ / 1_000_000 * TICK_1MS_US;
  localparam int TICKS_PER_10MS = 10;

  // Interrupt bits
  localparam int IRQ_SLEEP = 0;
  localparam int IRQ_WAKE  = 1;
  localparam int IRQ_REJ   = 2;
  localparam int IRQ_W     = 3;

endpackage : sleep_ctl_pkg
`default_nettype wire

// [rtl/tick_gen.sv]
`timescale 1ns/1ps
`default_nettype none
module tick_gen #(
  parameter int CYC = 20000
) (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      tick_1ms,
  output logic      tick_10ms
);
  typedef struct packed {
    logic [15:0] cyc;
    logic [3:0]  ms;
    logic        t1;
    logic        t10;
  } tick_st_t;

  tick_st_t st_r;
  tick_st_t st_nxt;

  always_comb begin
    st_nxt     = st_r;
    st_nxt.t1  = 1'b0;
    st_nxt.t10 = 1'b0;
    if (st_r.cyc == 16'(CYC - 1)) begin
      st_nxt.cyc = '0;
      st_nxt.t1  = 1'b1;
      if (st_r.ms == 4'(sleep_ctl_pkg::TICKS_PER_10MS - 1)) begin
        st_nxt.ms  = '0;
        st_nxt.t10 = 1'b1;
      end else begin
        st_nxt.ms = st_r.ms + 4'h1;
      end
    end else begin
      st_nxt.cyc = st_r.cyc + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick_1ms  = st_r.t1;
  assign tick_10ms = st_r.t10;
endmodule : tick_gen
`default_nettype wire

// [rtl/period_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module period_timer #(
  parameter int W = 22
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  input  wire logic         tick,
  output logic              done
);
  typedef struct packed {
    logic [W-1:0] left;
    logic         run;
    logic         done;
  } tmr_st_t;

  tmr_st_t st_r;
  tmr_st_t st_nxt;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    if (load) begin
      st_nxt.left = count;
      st_nxt.run  = 1'b1;
    end else if (st_r.run && tick) begin
      if (st_r.left <= W'(1)) begin
        st_nxt.run  = 1'b0;
        st_nxt.done = 1'b1;
      end else begin
        st_nxt.left = st_r.left - W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign done = st_r.done;
endmodule : period_timer
`default_nettype wire

// [rtl/radio_sleep_mode_control.sv]
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module radio_sleep_mode_control #(
  parameter int TICK_CYC = sleep_ctl_pkg::TICK_1MS_CYC,
  parameter int CHECK_MS = 1
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sleep_request_pin,
  input  wire logic        activity,
  input  wire logic        net_sync_wake,
  output logic             asleep,
  output logic             coordinator,
  output logic             status_msg_en,
  output logic             early_wake_en,
  output logic             node_equality,
  output logic             deploy_en,
  output logic             irq
);
  typedef enum logic [1:0] {
    ST_AWAKE,
    ST_SLEEP,
    ST_CHECK,
    ST_HOLD
  } phase_t;

  typedef struct packed {
    logic [3:0]  mode;
    logic [8:0]  opts;
    logic [21:0] sleep_per;
    logic [21:0] wake_per;
    logic [7:0]  rate;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    phase_t      phase;
    logic        asleep;
    logic        coord;
    logic        smsg;
    logic        early;
    logic        equal;
    logic        deploy;
    logic        irq;
    logic [31:0] prdata;
    logic        pslverr;
  } ctl_st_t;

  ctl_st_t st_r;
  ctl_st_t st_nxt;

  logic        tick_1ms;
  logic        tick_10ms;
  logic        sleep_done;
  logic        wake_done;
  logic        sleep_load;
  logic        wake_load;
  logic        wr;
  logic        rd;
  logic        mode_ok;
  logic        opts_ok;
  logic        val_ok;
  logic [3:0]  new_mode;
  logic [21:0] wake_cnt;
  logic        sync_mode;
  logic        async_cyc;
  logic        ev_sleep;
  logic        ev_wake;
  logic        ev_rej;

  tick_gen #(
    .CYC (TICK_CYC)
  ) u_tick (
    .pclk      (pclk),
    .presetn   (presetn),
    .tick_1ms  (tick_1ms),
    .tick_10ms (tick_10ms)
  );

  period_timer #(
    .W (22)
  ) u_sleep_tmr (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (sleep_load),
    .count   (st_r.sleep_per),
    .tick    (tick_10ms),
    .done    (sleep_done)
  );

  period_timer #(
    .W (22)
  ) u_wake_tmr (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (wake_load),
    .count   (wake_cnt),
    .tick    (tick_1ms),
    .done    (wake_done)
  );

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign new_mode = pwdata[3:0];

  // Mode legality
  always_comb begin
    mode_ok = 1'b0;
    if (pwdata[31:4] == '0) begin
      unique case (new_mode)
        sleep_ctl_pkg::MODE_AWAKE,
        sleep_ctl_pkg::MODE_PIN,
        sleep_ctl_pkg::MODE_CYCLIC,
        sleep_ctl_pkg::MODE_CYC_PIN,
        sleep_ctl_pkg::MODE_SUPPORT: mode_ok = 1'b1;
        sleep_ctl_pkg::MODE_SYNC:    mode_ok = 1'b1;
        default:                     mode_ok = 1'b0;
      endcase
      if ((new_mode == sleep_ctl_pkg::MODE_SUPPORT ||
           new_mode == sleep_ctl_pkg::MODE_SYNC) &&
          st_r.rate == 8'h00) begin
        mode_ok = 1'b0;
      end
    end
  end

  assign opts_ok = (pwdata[31:9] == '0) &&
                   (pwdata[8:0] <= sleep_ctl_pkg::OPTIONS_MAX) &&
                   !(pwdata[sleep_ctl_pkg::OPT_PREF_COORD] &&
                     pwdata[sleep_ctl_pkg::OPT_NON_COORD]);

  // Write legality per register
  always_comb begin
    unique case (paddr)
      sleep_ctl_pkg::ADDR_MODE:      val_ok = mode_ok;
      sleep_ctl_pkg::ADDR_OPTIONS:   val_ok = opts_ok;
      sleep_ctl_pkg::ADDR_SLEEP_PER:
        val_ok = pwdata[31:22] == '0 &&
                 pwdata[21:0] >= sleep_ctl_pkg::SLEEP_PER_MIN &&
                 pwdata[21:0] <= sleep_ctl_pkg::SLEEP_PER_MAX;
      sleep_ctl_pkg::ADDR_WAKE_PER:
        val_ok = pwdata[31:22] == '0 &&
                 pwdata[21:0] >= sleep_ctl_pkg::WAKE_PER_MIN &&
                 pwdata[21:0] <= sleep_ctl_pkg::WAKE_PER_MAX;
      sleep_ctl_pkg::ADDR_RATE:
        // Rate 0 would strand a synchronous mode
        val_ok = pwdata[31:8] == '0 &&
                 !(pwdata[7:0] == 8'h00 &&
                   (st_r.mode == sleep_ctl_pkg::MODE_SUPPORT ||
                    st_r.mode == sleep_ctl_pkg::MODE_SYNC));
      sleep_ctl_pkg::ADDR_IRQ_STAT,
      sleep_ctl_pkg::ADDR_IRQ_MASK:  val_ok = 1'b1;
      default:                       val_ok = 1'b0;
    endcase
  end

  assign sync_mode = st_r.mode == sleep_ctl_pkg::MODE_SYNC;
  assign async_cyc = st_r.mode == sleep_ctl_pkg::MODE_CYCLIC ||
                     st_r.mode == sleep_ctl_pkg::MODE_CYC_PIN;

  // Brief check window unless full wake is requested or the mode is synchronous
  assign wake_cnt = (st_r.phase == ST_SLEEP && !sync_mode &&
                     !st_r.opts[sleep_ctl_pkg::OPT_FULL_WAKE])
                    ? 22'(CHECK_MS) : st_r.wake_per;

  // Sequencer
  always_comb begin
    st_nxt     = st_r;
    sleep_load = 1'b0;
    wake_load  = 1'b0;
    ev_sleep   = 1'b0;
    ev_wake    = 1'b0;
    unique case (st_r.mode)
      sleep_ctl_pkg::MODE_PIN: begin
        st_nxt.phase = sleep_request_pin ? ST_SLEEP : ST_AWAKE;
      end
      sleep_ctl_pkg::MODE_CYCLIC,
      sleep_ctl_pkg::MODE_CYC_PIN,
      sleep_ctl_pkg::MODE_SYNC: begin
        if (st_r.mode == sleep_ctl_pkg::MODE_CYC_PIN &&
            !sleep_request_pin) begin
          st_nxt.phase = ST_AWAKE;
        end else begin
          unique case (st_r.phase)
            ST_AWAKE: begin
              st_nxt.phase = ST_SLEEP;
              sleep_load   = 1'b1;
            end
            ST_SLEEP: begin
              if (sleep_done || (sync_mode && net_sync_wake &&
                  !st_r.opts[sleep_ctl_pkg::OPT_NO_EARLY])) begin
                st_nxt.phase = async_cyc ? ST_CHECK : ST_HOLD;
                wake_load    = 1'b1;
              end
            end
            ST_CHECK: begin
              if (activity) begin
                st_nxt.phase = ST_HOLD;
                wake_load    = 1'b1;
              end else if (wake_done) begin
                st_nxt.phase = ST_SLEEP;
                sleep_load   = 1'b1;
              end
            end
            ST_HOLD: begin
              if (async_cyc && activity) begin
                wake_load = 1'b1;
              end else if (wake_done) begin
                st_nxt.phase = ST_SLEEP;
                sleep_load   = 1'b1;
              end
            end
          endcase
        end
      end
      default: begin
        st_nxt.phase = ST_AWAKE;
      end
    endcase
    st_nxt.asleep = st_nxt.phase == ST_SLEEP;
    ev_sleep = st_nxt.asleep && !st_r.asleep;
    ev_wake  = !st_nxt.asleep && st_r.asleep;

    // Option-driven roles, meaningful in synchronous modes
    st_nxt.coord  = (sync_mode || st_r.mode == sleep_ctl_pkg::MODE_SUPPORT)
                    && st_r.opts[sleep_ctl_pkg::OPT_PREF_COORD];
    if (st_r.opts[sleep_ctl_pkg::OPT_NON_COORD]) begin
      st_nxt.coord = 1'b0;
    end
    st_nxt.smsg   = st_r.opts[sleep_ctl_pkg::OPT_STATUS_MSG];
    st_nxt.early  = !st_r.opts[sleep_ctl_pkg::OPT_NO_EARLY];
    st_nxt.equal  = st_r.opts[sleep_ctl_pkg::OPT_EQUALITY];
    st_nxt.deploy = st_nxt.coord &&
                    !st_r.opts[sleep_ctl_pkg::OPT_NO_DEPLOY];

    // Bus access, zero wait states
    ev_rej          = wr && !val_ok;
    st_nxt.pslverr  = psel && !penable && !(pwrite ? val_ok :
                      (paddr <= sleep_ctl_pkg::ADDR_IRQ_MASK &&
                       paddr[1:0] == 2'b00));
    st_nxt.prdata   = '0;
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        sleep_ctl_pkg::ADDR_MODE:      st_nxt.prdata = 32'(st_r.mode);
        sleep_ctl_pkg::ADDR_OPTIONS:   st_nxt.prdata = 32'(st_r.opts);
        sleep_ctl_pkg::ADDR_SLEEP_PER: st_nxt.prdata = 32'(st_r.sleep_per);
        sleep_ctl_pkg::ADDR_WAKE_PER:  st_nxt.prdata = 32'(st_r.wake_per);
        sleep_ctl_pkg::ADDR_RATE:      st_nxt.prdata = 32'(st_r.rate);
        sleep_ctl_pkg::ADDR_STATUS:
          st_nxt.prdata = 32'({st_r.coord, st_r.phase, st_r.asleep});
        sleep_ctl_pkg::ADDR_IRQ_STAT:  st_nxt.prdata = 32'(st_r.irq_stat);
        sleep_ctl_pkg::ADDR_IRQ_MASK:  st_nxt.prdata = 32'(st_r.irq_mask);
        default:                       st_nxt.prdata = '0;
      endcase
    end
    if (wr && val_ok) begin
      unique case (paddr)
        sleep_ctl_pkg::ADDR_MODE:      st_nxt.mode = new_mode;
        sleep_ctl_pkg::ADDR_OPTIONS:   st_nxt.opts = pwdata[8:0];
        sleep_ctl_pkg::ADDR_SLEEP_PER: st_nxt.sleep_per = pwdata[21:0];
        sleep_ctl_pkg::ADDR_WAKE_PER:  st_nxt.wake_per = pwdata[21:0];
        sleep_ctl_pkg::ADDR_RATE:      st_nxt.rate = pwdata[7:0];
        sleep_ctl_pkg::ADDR_IRQ_STAT:
          st_nxt.irq_stat = st_r.irq_stat & ~pwdata[2:0];
        sleep_ctl_pkg::ADDR_IRQ_MASK:  st_nxt.irq_mask = pwdata[2:0];
        default:                       st_nxt.mode = st_r.mode;
      endcase
    end
    // Set after clear so a same-cycle event survives
    st_nxt.irq_stat = st_nxt.irq_stat | {ev_rej, ev_wake, ev_sleep};
    st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r           <= '0;
      st_r.mode      <= sleep_ctl_pkg::MODE_RST;
      st_r.opts      <= sleep_ctl_pkg::OPTIONS_RST;
      st_r.sleep_per <= sleep_ctl_pkg::SLEEP_PER_RST;
      st_r.wake_per  <= sleep_ctl_pkg::WAKE_PER_RST;
      st_r.rate      <= sleep_ctl_pkg::RATE_RST;
      st_r.early     <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata        = st_r.prdata;
  assign pslverr       = st_r.pslverr;
  assign pready        = 1'b1;
  assign asleep        = st_r.asleep;
  assign coordinator   = st_r.coord;
  assign status_msg_en = st_r.smsg;
  assign early_wake_en = st_r.early;
  assign node_equality = st_r.equal;
  assign deploy_en     = st_r.deploy;
  assign irq           = st_r.irq;
endmodule : radio_sleep_mode_control
`default_nettype wire

// [tb/sleep_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sleep_host_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic want_sleep,
  input  wire logic slow,
  output logic      sleep_request_pin
);
  logic [3:0] dly_r;
  // A slow host lags its own decision by a few cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) dly_r <= 4'h0;
    else dly_r <= {dly_r[2:0], want_sleep};
  end
  assign sleep_request_pin = slow ? dly_r[3] : dly_r[0];
endmodule : sleep_host_model
`default_nettype wire

// [tb/radio_sleep_mode_control_props.sv]
`timescale 1ns/1ps
`default_nettype none
module sleep_ctl_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sleep_request_pin,
  input wire logic        activity,
  input wire logic        net_sync_wake,
  input wire logic        asleep,
  input wire logic        coordinator,
  input wire logic        status_msg_en,
  input wire logic        early_wake_en,
  input wire logic        node_equality,
  input wire logic        deploy_en,
  input wire logic        irq
);
  logic [3:0] mode_r;
  logic [8:0] opt_r;
  logic [7:0] rate_r;
  logic       acc;
  logic       wok;
  assign acc = psel && penable && pwrite;
  assign wok = acc && !pslverr;
  // Mirror only the writes the device accepted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= 4'h0;
      opt_r  <= 9'h002;
      rate_r <= 8'h01;
    end else begin
      if (wok && paddr == 8'h00) mode_r <= pwdata[3:0];
      if (wok && paddr == 8'h04) opt_r <= pwdata[8:0];
      if (wok && paddr == 8'h10) rate_r <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  awake_modes_a: assert property (
    (mode_r inside {4'h0, 4'h7})[*3] |-> !asleep)
    else $error("asleep in an awake mode");
  pin_sleep_a: assert property (
    mode_r == 4'h1 && $rose(sleep_request_pin) |-> ##[1:3] asleep)
    else $error("pin sleep not followed");
  pin_wake_a: assert property (
    (mode_r == 4'h1 && !sleep_request_pin)[*4] |-> !asleep)
    else $error("pin wake not followed");
  pin_release_a: assert property (
    (mode_r == 4'h5 && !sleep_request_pin)[*4] |-> !asleep)
    else $error("asleep with pin released");
  bad_mode_a: assert property (
    acc && paddr == 8'h00 && (pwdata[3:0] inside {4'h2, 4'h3, 4'h6}
    || pwdata[3:0] > 4'h8) |-> pslverr)
    else $error("bad mode code taken");
  opt_pair_a: assert property (
    acc && paddr == 8'h04 && pwdata[1:0] == 2'h3 |-> pslverr)
    else $error("options with both role bits taken");
  opt_range_a: assert property (
    acc && paddr == 8'h04 && pwdata > 32'h13E |-> pslverr)
    else $error("options out of range taken");
  sync_rate_a: assert property (
    acc && paddr == 8'h00 && pwdata[3:0] inside {4'h7, 4'h8}
    && rate_r == 8'h00 |-> pslverr)
    else $error("sync mode taken at rate zero");
  no_coord_a: assert property (
    opt_r[1] && $past(opt_r[1]) |-> !coordinator)
    else $error("coordinator despite non-coordinator bit");
  opt_flags_a: assert property (
    opt_r == $past(opt_r) && opt_r == $past(opt_r, 2) |->
    status_msg_en == opt_r[2] && early_wake_en == !opt_r[3]
    && node_equality == opt_r[4])
    else $error("option flags disagree with options");
  deploy_coord_a: assert property (
    deploy_en |-> coordinator)
    else $error("deployment without coordinator");
  cyc_wake_c: cover property (mode_r == 4'h4 && $fell(asleep));
  coord_on_c: cover property (coordinator && deploy_en);
  refused_c: cover property (acc && pslverr);
endmodule : sleep_ctl_props
bind radio_sleep_mode_control sleep_ctl_props u_props (.*);
`default_nettype wire

// [tb/radio_sleep_mode_control_test.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, x, s) begin \
  checks_done++; \
  if ((s) !== (x)) begin \
    mismatches++; \
    $display("mismatch %s exp %0h got %0h", n, x, s); \
  end \
end
module radio_sleep_mode_control_test;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr;
  logic        sleep_request_pin, activity, net_sync_wake, asleep, irq;
  logic        coordinator, status_msg_en, early_wake_en, node_equality;
  logic        deploy_en, want, slow, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [8:0]  cur, v;
  logic [3:0]  bad [5] = '{4'h2, 4'h3, 4'h6, 4'h9, 4'hF};
  int          mismatches, checks_done, n;

  radio_sleep_mode_control #(.TICK_CYC(4), .CHECK_MS(1)) u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sleep_request_pin, .activity, .net_sync_wake,
    .asleep, .coordinator, .status_msg_en, .early_wake_en, .node_equality,
    .deploy_en, .irq
  );
  sleep_host_model u_host (
    .pclk, .presetn, .want_sleep(want), .slow, .sleep_request_pin
  );

  always #25 pclk = ~pclk;

  function automatic logic ok_opt(input logic [8:0] x);
    return x <= 9'h13E && x[1:0] != 2'h3;
  endfunction : ok_opt

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic x);
    apb(1'b1, a, d);
    `CHK("pslverr", x, e)
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK("prdata", x, q)
  endtask : rd

  task automatic wait_sl(input logic x, input int lim);
    n = 0;
    while (asleep !== x && n < lim) begin
      n++;
      @(posedge pclk);
    end
    `CHK("asleep", x, asleep)
  endtask : wait_sl

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    // Driven late in the step so the reset edge is never missed
    {psel, penable, pwrite, want, slow, activity, net_sync_wake} <= '0;
    presetn <= 1'b0;
    paddr <= '0;
    pwdata <= '0;
    void'($urandom(25311));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h2);
    rd(8'h08, 32'h12C);
    rd(8'h0C, 32'hD08);
    rd(8'h10, 32'h1);
    rd(8'h1C, 32'h0);
    rd(8'h14, 32'h0);
    rd(8'h18, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped", 1'b1, e)
    $display("test reset values done");
    foreach (bad[i]) wr(8'h00, {28'h0, bad[i]}, 1'b1);
    rd(8'h00, 32'h0);
    wr(8'h04, 32'h3, 1'b1);
    wr(8'h04, 32'h13F, 1'b1);
    wr(8'h04, 32'h13E, 1'b0);
    wr(8'h08, 32'h0, 1'b1);
    wr(8'h08, 32'h15F901, 1'b1);
    wr(8'h08, 32'h15F900, 1'b0);
    wr(8'h0C, 32'h36EE81, 1'b1);
    wr(8'h0C, 32'h0, 1'b1);
    wr(8'h00, 32'h8, 1'b0);
    wr(8'h10, 32'h0, 1'b1);
    wr(8'h00, 32'h0, 1'b0);
    wr(8'h10, 32'h0, 1'b0);
    wr(8'h00, 32'h7, 1'b1);
    wr(8'h00, 32'h8, 1'b1);
    wr(8'h10, 32'h1, 1'b0);
    $display("test refusals done");
    wr(8'h00, 32'h7, 1'b0);
    cur = 9'h13E;
    repeat (24) begin
      v = 9'($urandom % 32'h140);
      wr(8'h04, {23'h0, v}, !ok_opt(v));
      if (ok_opt(v)) cur = v;
      repeat (2) @(posedge pclk);
      `CHK("coord", cur[0], coordinator)
      `CHK("status", cur[2], status_msg_en)
      `CHK("early", !cur[3], early_wake_en)
      `CHK("equal", cur[4], node_equality)
      `CHK("deploy", cur[0] & !cur[5], deploy_en)
      `CHK("awake", 1'b0, asleep)
    end
    $display("test options done");
    for (int m = 1; m <= 5; m += 4) begin
      slow <= 1'($urandom % 2);
      wr(8'h00, 32'(m), 1'b0);
      want <= 1'b1;
      wait_sl(1'b1, 12);
      want <= 1'b0;
      wait_sl(1'b0, 12);
      repeat (60) @(posedge pclk);
      `CHK("stay", 1'b0, asleep)
    end
    $display("test pin modes done");
    wr(8'h08, 32'h3, 1'b0);
    wr(8'h0C, 32'hA, 1'b0);
    for (int b = 0; b < 2; b++) begin
      wr(8'h04, b ? 32'h100 : 32'h0, 1'b0);
      wr(8'h00, 32'h4, 1'b0);
      wait_sl(1'b1, 12);
      wait_sl(1'b0, 200);
      `CHK("sleep len", 1'b1, n >= 75 && n <= 165)
      wait_sl(1'b1, 60);
      `CHK("wake len", b[0], n > 20)
      wr(8'h00, 32'h0, 1'b0);
    end
    wr(8'h04, 32'h0, 1'b0);
    wr(8'h00, 32'h4, 1'b0);
    wait_sl(1'b1, 12);
    wait_sl(1'b0, 200);
    // Activity inside the check window holds the device awake
    activity <= 1'b1;
    @(posedge pclk);
    activity <= 1'b0;
    wait_sl(1'b1, 60);
    `CHK("hold len", 1'b1, n > 20)
    wr(8'h00, 32'h0, 1'b0);
    wr(8'h00, 32'h8, 1'b0);
    wait_sl(1'b1, 12);
    wait_sl(1'b0, 200);
    wait_sl(1'b1, 60);
    net_sync_wake <= 1'b1;
    @(posedge pclk);
    net_sync_wake <= 1'b0;
    wait_sl(1'b0, 4);
    wr(8'h04, 32'h8, 1'b0);
    wait_sl(1'b1, 60);
    net_sync_wake <= 1'b1;
    @(posedge pclk);
    net_sync_wake <= 1'b0;
    repeat (4) @(posedge pclk);
    `CHK("no early", 1'b1, asleep)
    wr(8'h00, 32'h0, 1'b0);
    $display("test cyclic done");
    wait_sl(1'b0, 12);
    rd(8'h18, 32'h7);
    wr(8'h1C, 32'h1, 1'b0);
    @(posedge pclk);
    `CHK("irq on", 1'b1, irq)
    wr(8'h18, 32'h7, 1'b0);
    @(posedge pclk);
    `CHK("irq off", 1'b0, irq)
    wr(8'h1C, 32'h0, 1'b0);
    $display("test interrupt done");
    tally_and_finish();
  end
endmodule : radio_sleep_mode_control_test
`default_nettype wire
